// file: redriver_channel_config_regs.sv
// Channel configuration registers of one bank of a four-channel redriver.
// Assumes the serial bus target outside matches this bank's own address and
// presents byte reads and writes on a plain same-clock register port.
//
// Contract
// - Offset 0x03 bits 6:3 hold boost shape, reset zero; bit 7 reads zero.
// - Offset 0x03 bits 2:0 pick flat gain: 0,1,3,5,7 = -6,-4,-2,0,+2 dB.
// - Term sense force bit 2 bypasses detection and always reports termination.
// - Bit 1 enables additional termination polling.
// - Bit 0 asks two or three consecutive valid polls, only with extra polling.
// - Takeover bit 7 makes register power enables replace normal power control.
// - Bits 6:0 are block power enables, reset 0x7F.
// - Offset 0x06 bias field bits 5:3, reset 0x20, other bits read zero.
// - Offset 0x01 decodes skip bit 7, first code 6:3, second code 2:0.
// - Indices 0..2 set skip with first codes 0,1,3; default clears all.
// - Boost shape per index: 1,3,7,15 by index group, zero otherwise.
// - Each bank answers its own bus address; no bank selection here.
// - Channels sit at 0x00..0x60; 0x80 writes all, reads channel zero.
`default_nettype none

module redriver_channel_config_regs (
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic [3:0] POLL_STROBE,
   input wire logic [3:0] POLL_VALID,
   input wire logic [27:0] NORMAL_PWR_EN,
   output logic [3:0] TERM_PRESENT,
   output logic [3:0] FIRST_BOOST_SKIP,
   output logic [15:0] FIRST_BOOST_CODE,
   output logic [11:0] SECOND_BOOST_CODE,
   output logic [15:0] MIDBAND_BOOST_SHAPE,
   output logic [11:0] DC_LEVEL_SELECT,
   output logic [27:0] BLOCK_PWR_EN,
   output logic [11:0] BIAS_LEVEL
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_q;
   logic rst_meta_d;
   logic rst_sync_q;
   logic rst_sync_d;
   logic rst_n;

   always_comb begin
      rst_meta_d = 1'b1;
      rst_sync_d = rst_meta_q;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= rst_meta_d;
         rst_sync_q <= rst_sync_d;
      end
   end

   assign rst_n = rst_sync_q;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   logic [2:0] window;
   logic [4:0] reg_ofs;
   logic [3:0] wr_sel;
   logic [1:0] rd_ch;
   logic rd_hit;
   localparam logic [1:0] CH_SEL_NONE = 2'h0;

   assign window = REG_ADDR[7:5];
   assign reg_ofs = REG_ADDR[4:0];

   // Bank address matching is done by the bus target outside
   always_comb begin
      wr_sel = 4'h0;
      rd_ch = CH_SEL_NONE;
      rd_hit = 1'b0;
      if (!REG_ADDR[7]) begin
         wr_sel = 4'(4'h1 << REG_ADDR[6:5]);
         rd_ch = REG_ADDR[6:5];
         rd_hit = 1'b1;
      end else begin
         unique case (window)
            redriver_cfg_pkg::WIN_BCAST_ALL: begin
               wr_sel = 4'hF;
               rd_ch = redriver_cfg_pkg::CH_FIRST;
               rd_hit = 1'b1;
            end
            redriver_cfg_pkg::WIN_BCAST_LOW: begin
               wr_sel = 4'h3;
               rd_ch = redriver_cfg_pkg::CH_FIRST;
               rd_hit = 1'b1;
            end
            redriver_cfg_pkg::WIN_BCAST_HIGH: begin
               wr_sel = 4'hC;
               rd_ch = redriver_cfg_pkg::CH_THIRD;
               rd_hit = 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   logic [7:0] ch_rdata [redriver_cfg_pkg::NUM_CHANNELS];
   logic [7:0] ch_eq [redriver_cfg_pkg::NUM_CHANNELS];
   logic [7:0] ch_sg [redriver_cfg_pkg::NUM_CHANNELS];
   logic [2:0] ch_ts [redriver_cfg_pkg::NUM_CHANNELS];

   for (genvar c = 0; c < redriver_cfg_pkg::NUM_CHANNELS; c++) begin : g_ch
      channel_cfg_regs u_regs (
         .clk(SYS_CLK),
         .rst_n(rst_n),
         .wr_en(REG_WR & wr_sel[c]),
         .offset(reg_ofs),
         .wdata(REG_WDATA),
         .normal_pwr_en(NORMAL_PWR_EN[c*7 +: 7]),
         .rdata(ch_rdata[c]),
         .eq_ctrl(ch_eq[c]),
         .shape_gain(ch_sg[c]),
         .term_ctrl(ch_ts[c]),
         .pwr_en(BLOCK_PWR_EN[c*7 +: 7]),
         .bias_level(BIAS_LEVEL[c*3 +: 3])
      );

      term_poll_filter u_poll (
         .clk(SYS_CLK),
         .rst_n(rst_n),
         .poll_strobe(POLL_STROBE[c]),
         .poll_valid(POLL_VALID[c]),
         .sense_force(ch_ts[c][2]),
         .extra_poll(ch_ts[c][1]),
         .count_sel(ch_ts[c][0]),
         .present(TERM_PRESENT[c])
      );

      assign FIRST_BOOST_SKIP[c] = ch_eq[c][7];
      assign FIRST_BOOST_CODE[c*4 +: 4] = ch_eq[c][6:3];
      assign SECOND_BOOST_CODE[c*3 +: 3] = ch_eq[c][2:0];
      assign MIDBAND_BOOST_SHAPE[c*4 +: 4] = ch_sg[c][6:3];
      assign DC_LEVEL_SELECT[c*3 +: 3] = ch_sg[c][2:0];
   end

   // ---------------------------------------------------------------
   // Read answer, one cycle after the strobe
   // ---------------------------------------------------------------
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic rvalid_q;
   logic rvalid_d;

   always_comb begin
      rvalid_d = REG_RD;
      rdata_d = rdata_q;
      if (REG_RD) begin
         rdata_d = rd_hit ? ch_rdata[rd_ch] : 8'h00;
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign REG_RVALID = rvalid_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK);
   endclocking

   default disable iff (!rst_n);

   shape_rsvd_a: assert property (
      (REG_RD && !REG_ADDR[7] && reg_ofs == redriver_cfg_pkg::OFS_SHAPE_GAIN)
      |=> !REG_RDATA[7])
      else $error("shape register bit 7 read as one");

   gain_write_a: assert property (
      (REG_WR && REG_ADDR == 8'h23) |=>
         (DC_LEVEL_SELECT[5:3] == $past(REG_WDATA[2:0]) && MIDBAND_BOOST_SHAPE[7:4] == $past(REG_WDATA[6:3])))
      else $error("shape and gain write not applied to channel one");

   bias_rsvd_a: assert property (
      (REG_RD && reg_ofs == redriver_cfg_pkg::OFS_BIAS && window != 3'h7) |=>
         (REG_RDATA[7:6] == 2'h0 && REG_RDATA[2:0] == 3'h0))
      else $error("bias reserved bits read as nonzero");

   eq_decode_a: assert property (
      (REG_WR && REG_ADDR == 8'h41) |=>
         ({FIRST_BOOST_SKIP[2], FIRST_BOOST_CODE[11:8], SECOND_BOOST_CODE[8:6]} == $past(REG_WDATA)))
      else $error("equalizer fields of channel two not decoded");

   pwr_off_a: assert property (
      (REG_WR && wr_sel[0] && reg_ofs == redriver_cfg_pkg::OFS_PWR_TAKEOVER && REG_WDATA == 8'h80)
      |-> ##2 BLOCK_PWR_EN[6:0] == redriver_cfg_pkg::PWR_ALL_OFF)
      else $error("takeover with zero enables left blocks powered");

   pwr_bcast_a: assert property (
      (REG_WR && REG_ADDR == 8'h85 && REG_WDATA == 8'hFF) |-> ##2
         (BLOCK_PWR_EN == {4{redriver_cfg_pkg::PWR_ALL_ON}}))
      else $error("broadcast power write did not reach every channel");

   force_term_a: assert property (
      (REG_WR && wr_sel[0] && reg_ofs == redriver_cfg_pkg::OFS_TERM_SENSE && REG_WDATA[2])
      |-> ##2 TERM_PRESENT[0])
      else $error("forced termination not reported on channel zero");

   unmapped_a: assert property (
      (REG_RD && (REG_ADDR[7:5] == 3'h7 || reg_ofs == 5'h02 || reg_ofs > redriver_cfg_pkg::OFS_BIAS))
      |=> (REG_RVALID && REG_RDATA == 8'h00))
      else $error("unmapped offset read as nonzero");

   bcast_read_a: assert property (
      (REG_RD && window == redriver_cfg_pkg::WIN_BCAST_ALL && reg_ofs == redriver_cfg_pkg::OFS_EQ_CTRL)
      |=> REG_RDATA == {FIRST_BOOST_SKIP[0], FIRST_BOOST_CODE[3:0], SECOND_BOOST_CODE[2:0]})
      else $error("broadcast window read did not return channel zero");

   half_read_a: assert property (
      (REG_RD && window == redriver_cfg_pkg::WIN_BCAST_HIGH && reg_ofs == redriver_cfg_pkg::OFS_EQ_CTRL)
      |=> REG_RDATA == {FIRST_BOOST_SKIP[2], FIRST_BOOST_CODE[11:8], SECOND_BOOST_CODE[8:6]})
      else $error("upper pair window read did not return channel two");

   gain_bcast_a: assert property (
      (REG_WR && REG_ADDR == 8'h83)
      |=> DC_LEVEL_SELECT == {4{$past(REG_WDATA[2:0])}})
      else $error("broadcast gain write did not reach every channel");

   term_rsvd_a: assert property (
      (REG_RD && reg_ofs == redriver_cfg_pkg::OFS_TERM_SENSE && window != 3'h7)
      |=> REG_RDATA[7:3] == 5'h00)
      else $error("termination control reserved bits read as nonzero");

   bias_write_a: assert property (
      (REG_WR && REG_ADDR == 8'h26)
      |=> BIAS_LEVEL[5:3] == $past(REG_WDATA[5:3]))
      else $error("bias write not applied to channel one");

   takeover_off_a: assert property (
      (REG_WR && wr_sel[0] && reg_ofs == redriver_cfg_pkg::OFS_PWR_TAKEOVER && !REG_WDATA[7])
      |-> ##2 BLOCK_PWR_EN[6:0] == $past(NORMAL_PWR_EN[6:0]))
      else $error("normal power control not restored without takeover");

   cover_bcast_wr_c: cover property (REG_WR && window == redriver_cfg_pkg::WIN_BCAST_ALL);
   cover_takeover_c: cover property (REG_WR && reg_ofs == redriver_cfg_pkg::OFS_PWR_TAKEOVER && REG_WDATA[7]);
   cover_term_c: cover property ($rose(TERM_PRESENT[0]));
   cover_read_c: cover property (REG_RD ##1 REG_RVALID);
   cover_force_c: cover property (REG_WR && reg_ofs == redriver_cfg_pkg::OFS_TERM_SENSE && REG_WDATA[2]);

endmodule

`default_nettype wire

// file: redriver_cfg_pkg.sv
// Constants shared by the channel configuration register bank.
// Assumes one management clock; the bus target outside supplies byte accesses.
`default_nettype none

package redriver_cfg_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NUM_CHANNELS = 4;
   localparam int NUM_BLOCKS = 7;
   localparam logic [2:0] WIN_BCAST_ALL = 3'h4;
   localparam logic [2:0] WIN_BCAST_LOW = 3'h5;
   localparam logic [2:0] WIN_BCAST_HIGH = 3'h6;
   localparam logic [1:0] CH_FIRST = 2'h0;
   localparam logic [1:0] CH_THIRD = 2'h2;

   // ---------------------------------------------------------------
   // Register offsets inside a channel window
   // ---------------------------------------------------------------
   localparam logic [4:0] OFS_EQ_CTRL = 5'h01;
   localparam logic [4:0] OFS_SHAPE_GAIN = 5'h03;
   localparam logic [4:0] OFS_TERM_SENSE = 5'h04;
   localparam logic [4:0] OFS_PWR_TAKEOVER = 5'h05;
   localparam logic [4:0] OFS_BIAS = 5'h06;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_EQ_CTRL = 8'h00;
   localparam logic [7:0] RST_SHAPE_GAIN = 8'h05;
   localparam logic [7:0] RST_TERM_SENSE = 8'h04;
   localparam logic [7:0] RST_PWR_TAKEOVER = 8'h7F;
   localparam logic [7:0] RST_BIAS = 8'h20;

   // ---------------------------------------------------------------
   // Writable bit masks, reserved bits are zero here
   // ---------------------------------------------------------------
   localparam logic [7:0] WMASK_SHAPE_GAIN = 8'h7F;
   localparam logic [7:0] WMASK_TERM_SENSE = 8'h07;
   localparam logic [7:0] WMASK_BIAS = 8'h38;
   localparam logic [6:0] PWR_ALL_OFF = 7'h00;
   localparam logic [6:0] PWR_ALL_ON = 7'h7F;

   // ---------------------------------------------------------------
   // Flat gain codes
   // ---------------------------------------------------------------
   localparam logic [2:0] DC_GAIN_M6 = 3'h0;
   localparam logic [2:0] DC_GAIN_M4 = 3'h1;
   localparam logic [2:0] DC_GAIN_M2 = 3'h3;
   localparam logic [2:0] DC_GAIN_0 = 3'h5;
   localparam logic [2:0] DC_GAIN_P2 = 3'h7;

   // ---------------------------------------------------------------
   // Poll counts before termination is declared
   // ---------------------------------------------------------------
   localparam logic [1:0] POLLS_PLAIN = 2'h1;
   localparam logic [1:0] POLLS_TWO = 2'h2;
   localparam logic [1:0] POLLS_THREE = 2'h3;

   localparam logic [4:0] EQ_INDEX_DEFAULT = 5'h1F;

   // Equalizer index to {offset 0x01 value, boost shape}
   function automatic logic [11:0] eq_index_encode(input logic [4:0] index);
      logic [11:0] r;
      r = 12'h000;
      unique case (index)
         5'h00: r = {8'h80, 4'h0};
         5'h01: r = {8'h88, 4'h0};
         5'h02: r = {8'h98, 4'h0};
         5'h05: r = {8'h00, 4'h1};
         5'h06: r = {8'h08, 4'h1};
         5'h07: r = {8'h10, 4'h1};
         5'h08: r = {8'h18, 4'h3};
         5'h09: r = {8'h20, 4'h3};
         5'h0A: r = {8'h29, 4'h7};
         5'h0B: r = {8'h31, 4'h7};
         5'h0C: r = {8'h41, 4'h7};
         5'h0D: r = {8'h51, 4'h7};
         5'h0E: r = {8'h52, 4'hF};
         5'h0F: r = {8'h5B, 4'hF};
         5'h10: r = {8'h64, 4'hF};
         5'h11: r = {8'h6D, 4'hF};
         5'h12: r = {8'h76, 4'hF};
         5'h13: r = {8'h7F, 4'hF};
         default: r = {8'h00, 4'h0};
      endcase
      return r;
   endfunction

endpackage

`default_nettype wire

// file: term_poll_filter.sv
// Consecutive-poll filter for receiver termination of one channel.
// Assumes poll strobes come from the detection logic on the same clock.
`default_nettype none

module term_poll_filter (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic poll_strobe,
   input wire logic poll_valid,
   input wire logic sense_force,
   input wire logic extra_poll,
   input wire logic count_sel,
   output logic present
);

   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic found_q;
   logic found_d;
   logic present_q;
   logic present_d;
   logic [1:0] need;
   logic [1:0] cnt_inc;

   // ---------------------------------------------------------------
   // Counting
   // ---------------------------------------------------------------
   always_comb begin
      need = redriver_cfg_pkg::POLLS_PLAIN;
      if (extra_poll) begin
         need = count_sel ? redriver_cfg_pkg::POLLS_THREE : redriver_cfg_pkg::POLLS_TWO;
      end
      cnt_inc = (cnt_q == redriver_cfg_pkg::POLLS_THREE) ? cnt_q : 2'(cnt_q + 2'h1);
      cnt_d = cnt_q;
      found_d = found_q;
      if (poll_strobe) begin
         if (poll_valid) begin
            cnt_d = cnt_inc;
            found_d = (cnt_inc >= need);
         end else begin
            cnt_d = 2'h0;
            found_d = 1'b0;
         end
      end
      present_d = sense_force | found_d;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 2'h0;
         found_q <= 1'b0;
         present_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         found_q <= found_d;
         present_q <= present_d;
      end
   end

   assign present = present_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   poll_three_a: assert property (@(posedge clk) disable iff (!rst_n)
      (poll_strobe && poll_valid && extra_poll && count_sel && cnt_q == 2'h1 && !found_q && !sense_force)
      |=> !present_q)
      else $error("termination declared after two polls in three-poll mode");

   poll_extra_a: assert property (@(posedge clk) disable iff (!rst_n)
      (poll_strobe && poll_valid && extra_poll && cnt_q == 2'h0 && !sense_force) |=> !present_q)
      else $error("termination declared after one poll with extra polling");

   poll_force_a: assert property (@(posedge clk) disable iff (!rst_n)
      sense_force |=> present_q)
      else $error("forced termination not reported");

endmodule

`default_nettype wire

// file: channel_cfg_regs.sv
// Register set of one redriver channel.
// Assumes a one-cycle write strobe with offset and data from the bank decoder.
`default_nettype none

module channel_cfg_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [4:0] offset,
   input wire logic [7:0] wdata,
   input wire logic [6:0] normal_pwr_en,
   output logic [7:0] rdata,
   output logic [7:0] eq_ctrl,
   output logic [7:0] shape_gain,
   output logic [2:0] term_ctrl,
   output logic [6:0] pwr_en,
   output logic [2:0] bias_level
);

   logic [7:0] eq_q, eq_d;
   logic [7:0] sg_q, sg_d;
   logic [7:0] ts_q, ts_d;
   logic [7:0] pt_q, pt_d;
   logic [7:0] bi_q, bi_d;
   logic [6:0] pwr_q, pwr_d;

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   always_comb begin
      eq_d = eq_q;
      sg_d = sg_q;
      ts_d = ts_q;
      pt_d = pt_q;
      bi_d = bi_q;
      if (wr_en) begin
         unique case (offset)
            redriver_cfg_pkg::OFS_EQ_CTRL: eq_d = wdata;
            redriver_cfg_pkg::OFS_SHAPE_GAIN: sg_d = wdata & redriver_cfg_pkg::WMASK_SHAPE_GAIN;
            redriver_cfg_pkg::OFS_TERM_SENSE: ts_d = wdata & redriver_cfg_pkg::WMASK_TERM_SENSE;
            redriver_cfg_pkg::OFS_PWR_TAKEOVER: pt_d = wdata;
            redriver_cfg_pkg::OFS_BIAS: bi_d = wdata & redriver_cfg_pkg::WMASK_BIAS;
            default: ;
         endcase
      end
      // Register enables replace normal control only under takeover
      pwr_d = pt_q[7] ? pt_q[6:0] : normal_pwr_en;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eq_q <= redriver_cfg_pkg::RST_EQ_CTRL;
         sg_q <= redriver_cfg_pkg::RST_SHAPE_GAIN;
         ts_q <= redriver_cfg_pkg::RST_TERM_SENSE;
         pt_q <= redriver_cfg_pkg::RST_PWR_TAKEOVER;
         bi_q <= redriver_cfg_pkg::RST_BIAS;
         pwr_q <= redriver_cfg_pkg::PWR_ALL_ON;
      end else begin
         eq_q <= eq_d;
         sg_q <= sg_d;
         ts_q <= ts_d;
         pt_q <= pt_d;
         bi_q <= bi_d;
         pwr_q <= pwr_d;
      end
   end

   // ---------------------------------------------------------------
   // Read mux, unmapped offsets read zero
   // ---------------------------------------------------------------
   always_comb begin
      rdata = 8'h00;
      unique case (offset)
         redriver_cfg_pkg::OFS_EQ_CTRL: rdata = eq_q;
         redriver_cfg_pkg::OFS_SHAPE_GAIN: rdata = sg_q;
         redriver_cfg_pkg::OFS_TERM_SENSE: rdata = ts_q;
         redriver_cfg_pkg::OFS_PWR_TAKEOVER: rdata = pt_q;
         redriver_cfg_pkg::OFS_BIAS: rdata = bi_q;
         default: rdata = 8'h00;
      endcase
   end

   assign eq_ctrl = eq_q;
   assign shape_gain = sg_q;
   assign term_ctrl = ts_q[2:0];
   assign pwr_en = pwr_q;
   assign bias_level = bi_q[5:3];

endmodule

`default_nettype wire

// file: redriver_host_model.sv
// Host model: byte reads, writes and masked updates on the bank port.
// Assumes the bank takes requests on the rising clock edge.
`default_nettype none

module redriver_host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr_en,
   output logic rd_en,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end

   // Released lines show the inverse so stale values never pass
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(posedge clk);
      #2;
      wr_en = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask

   task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk);
      #2;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk);
      #2;
      rd_en = 1'b0;
      addr = ~a;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (rvalid === 1'b1) begin
            d = rdata;
            ok = 1'b1;
         end else begin
            @(posedge clk);
            #2;
         end
      end
   endtask

   // Only the masked bits change, the rest stay as read
   task automatic update_masked(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m, output logic ok);
      logic [7:0] old;
      ok = 1'b1;
      old = 8'h00;
      if (m != 8'hFF) begin
         read_byte(a, old, ok);
      end
      write_byte(a, (old & ~m) | (d & m));
   endtask
endmodule

`default_nettype wire

// file: redriver_channel_config_regs_test.sv
// Self-checking bench for the channel configuration register bank.
// Assumes the host model drives the register port and the bench drives polls.
`default_nettype none

module redriver_channel_config_regs_test;
   timeunit 1ns;
   timeprecision 100ps;

   logic SYS_CLK = 1'b0;
   logic NRST = 1'b0;
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
   logic REG_WR, REG_RD, REG_RVALID;
   logic [3:0] POLL_STROBE = 4'h0;
   logic [3:0] POLL_VALID = 4'h0;
   logic [27:0] NORMAL_PWR_EN = 28'h5A3C96B;
   logic [3:0] TERM_PRESENT, FIRST_BOOST_SKIP;
   logic [15:0] FIRST_BOOST_CODE, MIDBAND_BOOST_SHAPE;
   logic [11:0] SECOND_BOOST_CODE, DC_LEVEL_SELECT, BIAS_LEVEL;
   logic [27:0] BLOCK_PWR_EN;
   int errors = 0;
   int total_checks = 0;
   localparam logic [7:0] EQ_REG [18] = '{8'h80, 8'h88, 8'h98, 8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h29,
      8'h31, 8'h41, 8'h51, 8'h52, 8'h5B, 8'h64, 8'h6D, 8'h76, 8'h7F};
   localparam logic [3:0] EQ_SHAPE [18] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h3, 4'h3, 4'h7,
      4'h7, 4'h7, 4'h7, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
   localparam logic [2:0] GAINS [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};

   always #25 SYS_CLK = ~SYS_CLK;

   redriver_channel_config_regs dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .REG_RVALID(REG_RVALID), .POLL_STROBE(POLL_STROBE), .POLL_VALID(POLL_VALID),
      .NORMAL_PWR_EN(NORMAL_PWR_EN), .TERM_PRESENT(TERM_PRESENT), .FIRST_BOOST_SKIP(FIRST_BOOST_SKIP),
      .FIRST_BOOST_CODE(FIRST_BOOST_CODE), .SECOND_BOOST_CODE(SECOND_BOOST_CODE),
      .MIDBAND_BOOST_SHAPE(MIDBAND_BOOST_SHAPE), .DC_LEVEL_SELECT(DC_LEVEL_SELECT),
      .BLOCK_PWR_EN(BLOCK_PWR_EN), .BIAS_LEVEL(BIAS_LEVEL));

   redriver_host_model host (.clk(SYS_CLK), .addr(REG_ADDR), .wdata(REG_WDATA), .wr_en(REG_WR),
      .rd_en(REG_RD), .rdata(REG_RDATA), .rvalid(REG_RVALID));

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.read_byte(a, d, ok);
      if (ok !== 1'b1) begin
         errors++;
      end
      check({24'h0, d}, {24'h0, exp});
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge SYS_CLK);
      #2;
   endtask

   task automatic poll(input logic v);
      @(posedge SYS_CLK);
      #2;
      POLL_STROBE[0] = 1'b1;
      POLL_VALID[0] = v;
      @(posedge SYS_CLK);
      #2;
      POLL_STROBE[0] = 1'b0;
      POLL_VALID[0] = ~v;
      cycles(1);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      rd_chk(8'h01, 8'h00);
      rd_chk(8'h03, 8'h05);
      rd_chk(8'h24, 8'h04);
      rd_chk(8'h45, 8'h7F);
      rd_chk(8'h66, 8'h20);
      check(DC_LEVEL_SELECT, {4{3'h5}});
      check(BIAS_LEVEL, {4{3'h4}});
      check(BLOCK_PWR_EN, NORMAL_PWR_EN);
      check(TERM_PRESENT, 4'hF);
      $display("test reset done");
   endtask

   task automatic test_reserved();
      host.write_byte(8'h23, 8'hFF);
      host.write_byte(8'h26, 8'hFF);
      host.write_byte(8'h27, 8'hFF);
      rd_chk(8'h23, 8'h7F);
      rd_chk(8'h26, 8'h38);
      rd_chk(8'h27, 8'h00);
      rd_chk(8'h20, 8'h00);
      check(MIDBAND_BOOST_SHAPE[7:4], 4'hF);
      check(BIAS_LEVEL[5:3], 3'h7);
      $display("test reserved done");
   endtask

   task automatic test_eq();
      logic ok;
      for (int i = 0; i < 18; i++) begin
         host.write_byte(8'h41, EQ_REG[i]);
         host.update_masked(8'h43, {1'b0, EQ_SHAPE[i], 3'h0}, 8'h78, ok);
         rd_chk(8'h43, {1'b0, EQ_SHAPE[i], 3'h5});
         check({FIRST_BOOST_SKIP[2], FIRST_BOOST_CODE[11:8], SECOND_BOOST_CODE[8:6]}, EQ_REG[i]);
         check(MIDBAND_BOOST_SHAPE[11:8], EQ_SHAPE[i]);
      end
      check(FIRST_BOOST_SKIP[2], 1'b0);
      for (int g = 0; g < 5; g++) begin
         host.update_masked(8'h83, {5'h00, GAINS[g]}, 8'h07, ok);
         cycles(1);
         check(DC_LEVEL_SELECT, {4{GAINS[g]}});
      end
      check(MIDBAND_BOOST_SHAPE, 16'h0000);
      host.write_byte(8'h41, 8'h00);
      cycles(1);
      check({FIRST_BOOST_SKIP[2], FIRST_BOOST_CODE[11:8], SECOND_BOOST_CODE[8:6]}, 8'h00);
      $display("test eq done");
   endtask

   task automatic test_window();
      host.write_byte(8'h81, 8'h98);
      for (int c = 0; c < 4; c++) begin
         rd_chk(8'((c << 5) + 1), 8'h98);
      end
      host.write_byte(8'hC1, 8'h10);
      host.write_byte(8'hA1, 8'h88);
      rd_chk(8'h81, 8'h88);
      rd_chk(8'hA1, 8'h88);
      rd_chk(8'hC1, 8'h10);
      rd_chk(8'h61, 8'h10);
      rd_chk(8'h21, 8'h88);
      rd_chk(8'hE1, 8'h00);
      $display("test window done");
   endtask

   task automatic test_power();
      host.write_byte(8'h85, 8'h80);
      cycles(2);
      check(BLOCK_PWR_EN, 28'h0000000);
      host.write_byte(8'h85, 8'hFF);
      cycles(2);
      check(BLOCK_PWR_EN, 28'hFFFFFFF);
      host.write_byte(8'h05, 8'h55);
      NORMAL_PWR_EN[6:0] = 7'h2A;
      cycles(2);
      check(BLOCK_PWR_EN[13:0], {7'h7F, 7'h2A});
      rd_chk(8'h05, 8'h55);
      host.write_byte(8'h85, 8'h7F);
      cycles(2);
      check(BLOCK_PWR_EN, NORMAL_PWR_EN);
      $display("test power done");
   endtask

   task automatic test_poll();
      host.write_byte(8'h04, 8'h00);
      poll(1'b0);
      check(TERM_PRESENT[0], 1'b0);
      poll(1'b1);
      check(TERM_PRESENT[0], 1'b1);
      host.write_byte(8'h04, 8'h02);
      poll(1'b0);
      poll(1'b1);
      check(TERM_PRESENT[0], 1'b0);
      poll(1'b1);
      check(TERM_PRESENT[0], 1'b1);
      host.write_byte(8'h04, 8'h03);
      poll(1'b0);
      poll(1'b1);
      poll(1'b1);
      check(TERM_PRESENT[0], 1'b0);
      poll(1'b1);
      check(TERM_PRESENT[0], 1'b1);
      host.write_byte(8'h04, 8'h04);
      poll(1'b0);
      check(TERM_PRESENT[0], 1'b1);
      $display("test poll done");
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge SYS_CLK);
      #2;
      NRST = 1'b1;
      cycles(3);
      test_reset();
      test_reserved();
      test_eq();
      test_window();
      test_power();
      test_poll();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge SYS_CLK);
      errors++;
      complete_run();
   end
endmodule

`default_nettype wire
